//--- logic/nbi_bus_interface.sv
// Shared address/data bus interface: slave register port and DMA master.
// Assumes synchronous pins; the pad ring builds each wire from the enables.
`timescale 1ns/1ps

module nbi_bus_interface (
    // Clock and reset.
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    // Shared address/data bus, enables active low.
    input wire logic [15:0] i_shared_addr_data_bus,
    output logic [15:0] o_shared_addr_data_bus,
    output logic o_bus_lo_oe_n,
    output logic o_bus_hi_oe_n,
    // Low address strobe, two-way.
    input wire logic i_low_address_strobe,
    output logic o_low_address_strobe,
    output logic o_low_address_strobe_oe_n,
    // Slave port pins.
    input wire logic i_slave_sel_n,
    input wire logic i_slave_read_strobe_n,
    input wire logic i_slave_write_strobe_n,
    input wire logic [3:0] i_register_select,
    output logic o_ack_n,
    // Master port pins.
    input wire logic i_bus_grant,
    input wire logic i_ready,
    output logic o_master_write_strobe_n,
    output logic o_master_read_strobe_n,
    output logic o_master_strobe_oe_n,
    // Register file side.
    input wire logic [7:0] i_reg_rdata,
    output logic o_reg_rd,
    output logic o_reg_wr,
    output logic [3:0] o_reg_sel,
    output logic [7:0] o_reg_wdata,
    // DMA request side.
    input wire logic i_dma_req,
    input wire logic i_dma_write,
    input wire logic i_byte_mode,
    input wire logic [15:0] i_dma_addr,
    input wire logic [15:0] i_dma_wdata,
    output logic o_dma_done,
    output logic [15:0] o_dma_rdata
);

    // ------------------------------------------------------------------
    // State and command registers
    // ------------------------------------------------------------------
    nbi_pkg::nbi_mst_e mst_q, mst_d;
    nbi_pkg::nbi_slv_e slv_q, slv_d;
    logic dir_wr_q;
    logic byte_q;
    logic slv_wr_q;
    logic [15:0] addr_q;
    logic [15:0] wdata_q;
    logic slv_acc;
    logic mst_start;
    logic mst_data_d;

    // A slave access needs chip select, a strobe and an idle master.
    assign slv_acc = !i_slave_sel_n && mst_q == nbi_pkg::NBI_M_IDLE
        && (!i_slave_read_strobe_n || !i_slave_write_strobe_n);
    // A cycle starts only once granted and no slave access is pending.
    assign mst_start = i_bus_grant && i_dma_req && !slv_acc
        && slv_q == nbi_pkg::NBI_S_IDLE;
    assign mst_data_d = mst_d == nbi_pkg::NBI_M_T2
        || mst_d == nbi_pkg::NBI_M_T3 || mst_d == nbi_pkg::NBI_M_TW;

    // ------------------------------------------------------------------
    // Master cycle sequencing
    // ------------------------------------------------------------------

    // Next master state; ready is looked at only in the third state and the wait state.
    always_comb begin
        mst_d = mst_q;
        case (mst_q)
            nbi_pkg::NBI_M_IDLE: begin
                if (mst_start) begin
                    mst_d = nbi_pkg::NBI_M_T1;
                end
            end
            nbi_pkg::NBI_M_T1: mst_d = nbi_pkg::NBI_M_T2;
            nbi_pkg::NBI_M_T2: mst_d = nbi_pkg::NBI_M_T3;
            nbi_pkg::NBI_M_T3: begin
                mst_d = i_ready ? nbi_pkg::NBI_M_TW
                                : nbi_pkg::NBI_M_T4;
            end
            nbi_pkg::NBI_M_TW: begin
                if (!i_ready) begin
                    mst_d = nbi_pkg::NBI_M_T4;
                end
            end
            nbi_pkg::NBI_M_T4: mst_d = nbi_pkg::NBI_M_IDLE;
            default: mst_d = nbi_pkg::NBI_M_IDLE;
        endcase
    end

    // Master state register.
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            mst_q <= nbi_pkg::NBI_M_IDLE;
        end else begin
            mst_q <= mst_d;
        end
    end

    // The command is frozen at the start so the user may change it freely.
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            dir_wr_q <= 1'b0;
            byte_q <= 1'b0;
            addr_q <= nbi_pkg::AD_RST;
            wdata_q <= nbi_pkg::AD_RST;
        end else if (mst_q == nbi_pkg::NBI_M_IDLE && mst_start) begin
            dir_wr_q <= i_dma_write;
            byte_q <= i_byte_mode;
            addr_q <= i_dma_addr;
            wdata_q <= i_dma_wdata;
        end
    end

    // Strobes float until grant; only one of them ever goes low.
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_master_write_strobe_n <= 1'b1;
            o_master_read_strobe_n <= 1'b1;
            o_master_strobe_oe_n <= 1'b1;
        end else begin
            o_master_strobe_oe_n <= !(i_bus_grant
                || mst_d != nbi_pkg::NBI_M_IDLE);
            o_master_write_strobe_n <= !(mst_data_d && dir_wr_q);
            o_master_read_strobe_n <= !(mst_data_d && !dir_wr_q);
        end
    end

    // Address strobe pulses high in the first state for external latches.
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_low_address_strobe <= 1'b0;
            o_low_address_strobe_oe_n <= 1'b1;
        end else begin
            o_low_address_strobe <= mst_d == nbi_pkg::NBI_M_T1;
            o_low_address_strobe_oe_n <= mst_d == nbi_pkg::NBI_M_IDLE;
        end
    end

    // Read data is taken on the edge where the read strobe rises.
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_dma_rdata <= nbi_pkg::AD_RST;
            o_dma_done <= 1'b0;
        end else begin
            o_dma_done <= mst_q == nbi_pkg::NBI_M_T4;
            if (mst_d == nbi_pkg::NBI_M_T4 && mst_q != nbi_pkg::NBI_M_T4
                && !dir_wr_q) begin
                o_dma_rdata <= i_shared_addr_data_bus;
            end
        end
    end

    // ------------------------------------------------------------------
    // Slave register access
    // ------------------------------------------------------------------

    // One sync state before acknowledge; the host waits until then.
    always_comb begin
        slv_d = slv_q;
        case (slv_q)
            nbi_pkg::NBI_S_IDLE: begin
                if (slv_acc) begin
                    slv_d = nbi_pkg::NBI_S_SYNC;
                end
            end
            nbi_pkg::NBI_S_SYNC: begin
                slv_d = slv_acc ? nbi_pkg::NBI_S_ACK
                                : nbi_pkg::NBI_S_IDLE;
            end
            nbi_pkg::NBI_S_ACK: begin
                if (!slv_acc) begin
                    slv_d = nbi_pkg::NBI_S_IDLE;
                end
            end
            default: slv_d = nbi_pkg::NBI_S_IDLE;
        endcase
    end

    // Slave state and the direction chosen by the host's strobe.
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            slv_q <= nbi_pkg::NBI_S_IDLE;
            slv_wr_q <= 1'b0;
        end else begin
            slv_q <= slv_d;
            if (slv_q == nbi_pkg::NBI_S_IDLE && slv_acc) begin
                slv_wr_q <= !i_slave_write_strobe_n;
            end
        end
    end

    // One pulse per access towards the register file; a read pulses before acknowledge, a write with it.
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_reg_rd <= 1'b0;
            o_reg_wr <= 1'b0;
            o_reg_wdata <= nbi_pkg::BYTE_RST;
            o_ack_n <= 1'b1;
        end else begin
            o_reg_rd <= slv_q == nbi_pkg::NBI_S_IDLE && slv_acc
                && !i_slave_read_strobe_n;
            o_reg_wr <= slv_q == nbi_pkg::NBI_S_SYNC && slv_acc
                && slv_wr_q;
            if (slv_q == nbi_pkg::NBI_S_SYNC && slv_wr_q) begin
                o_reg_wdata <= i_shared_addr_data_bus[nbi_pkg::LO_MSB:0];
            end
            o_ack_n <= slv_d != nbi_pkg::NBI_S_ACK;
        end
    end

    // Register select latch; it only listens in slave mode.
    nbi_sel_latch u_sel_latch (
        .i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn),
        .i_en(!i_slave_sel_n && mst_q == nbi_pkg::NBI_M_IDLE),
        .i_strobe(i_low_address_strobe),
        .i_sel(i_register_select),
        .o_sel_q(o_reg_sel)
    );

    // ------------------------------------------------------------------
    // Shared bus drive
    // ------------------------------------------------------------------

    // Drive follows the next state so pins change on the state edge.
    // The upper byte never drives in slave mode, which keeps it off
    // the host's data path.
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_shared_addr_data_bus <= nbi_pkg::AD_RST;
            o_bus_lo_oe_n <= 1'b1;
            o_bus_hi_oe_n <= 1'b1;
        end else if (mst_d == nbi_pkg::NBI_M_T1) begin
            // The address register loads on this same edge, so the pins
            // take the request input that it is loading from.
            o_shared_addr_data_bus <= i_dma_addr;
            o_bus_lo_oe_n <= 1'b0;
            o_bus_hi_oe_n <= 1'b0;
        end else if (mst_data_d || mst_d == nbi_pkg::NBI_M_T4) begin
            // Write data stays until the fourth state ends.
            o_bus_lo_oe_n <= !dir_wr_q;
            o_shared_addr_data_bus[nbi_pkg::LO_MSB:0] <=
                wdata_q[nbi_pkg::LO_MSB:0];
            if (byte_q) begin
                o_shared_addr_data_bus[nbi_pkg::HI_MSB:nbi_pkg::HI_LSB] <=
                    addr_q[nbi_pkg::HI_MSB:nbi_pkg::HI_LSB];
                o_bus_hi_oe_n <= 1'b0;
            end else begin
                o_shared_addr_data_bus[nbi_pkg::HI_MSB:nbi_pkg::HI_LSB] <=
                    wdata_q[nbi_pkg::HI_MSB:nbi_pkg::HI_LSB];
                o_bus_hi_oe_n <= !dir_wr_q;
            end
        end else if (slv_q == nbi_pkg::NBI_S_SYNC && !slv_wr_q
            && slv_acc) begin
            o_shared_addr_data_bus[nbi_pkg::LO_MSB:0] <= i_reg_rdata;
            o_bus_lo_oe_n <= 1'b0;
            o_bus_hi_oe_n <= 1'b1;
        end else if (slv_d != nbi_pkg::NBI_S_ACK || slv_wr_q) begin
            o_bus_lo_oe_n <= 1'b1;
            o_bus_hi_oe_n <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence slv_start_s;
        slv_q == nbi_pkg::NBI_S_IDLE && slv_acc;
    endsequence

    sequence wait_entry_s;
        mst_q == nbi_pkg::NBI_M_T3 && i_ready;
    endsequence

    first_addr_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        mst_q == nbi_pkg::NBI_M_T1 |-> o_shared_addr_data_bus == addr_q
        && !o_bus_lo_oe_n && !o_bus_hi_oe_n && o_low_address_strobe
        && !o_low_address_strobe_oe_n)
        else $error("Address not driven in first state.");

    word_write_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        (mst_q == nbi_pkg::NBI_M_T4 && dir_wr_q && !byte_q)
        |-> o_shared_addr_data_bus == wdata_q && !o_bus_hi_oe_n)
        else $error("Word write data missing at strobe rise.");

    byte_hi_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        (mst_q == nbi_pkg::NBI_M_T2 && byte_q) |-> !o_bus_hi_oe_n
        && o_shared_addr_data_bus[15:8] == addr_q[15:8])
        else $error("Upper address byte lost in byte mode.");

    write_strobe_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        (mst_q == nbi_pkg::NBI_M_T2 && dir_wr_q) |-> !o_master_write_strobe_n
        && o_master_read_strobe_n ##1 !o_master_write_strobe_n)
        else $error("Write strobe not low in second and third states.");

    read_strobe_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        (mst_q == nbi_pkg::NBI_M_TW && !dir_wr_q)
        |-> !o_master_read_strobe_n && o_master_write_strobe_n)
        else $error("Read strobe not low in wait state.");

    read_capture_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        $rose(o_master_read_strobe_n) |-> o_dma_rdata
        == $past(i_shared_addr_data_bus))
        else $error("Read data not taken at strobe rise.");

    strobe_float_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        (mst_q == nbi_pkg::NBI_M_IDLE && !i_bus_grant)
        |=> o_master_strobe_oe_n)
        else $error("Master strobes driven without grant.");

    wait_state_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        wait_entry_s |=> mst_q == nbi_pkg::NBI_M_TW)
        else $error("Ready in third state did not add a wait.");

    ack_grant_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        slv_start_s ##1 slv_acc |=> !o_ack_n)
        else $error("Acknowledge late for slave access.");

    io_float_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        slv_q != nbi_pkg::NBI_S_IDLE |-> o_bus_hi_oe_n)
        else $error("Upper byte driven during register access.");

    slave_read_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        (slv_q == nbi_pkg::NBI_S_ACK && !slv_wr_q) |-> !o_bus_lo_oe_n)
        else $error("Register read data not driven.");

endmodule : nbi_bus_interface

//--- logic/nbi_pkg.sv
// Shared constants and state types for the network bus interface.
// Assumes one clock domain and the shared bus split into in, out and enable.
package nbi_pkg;

    // ------------------------------------------------------------------
    // Widths and field positions
    // ------------------------------------------------------------------
    localparam int unsigned AD_W = 16;
    localparam int unsigned BYTE_W = 8;
    localparam int unsigned SEL_W = 4;
    localparam int unsigned HI_LSB = 8;
    localparam int unsigned HI_MSB = 15;
    localparam int unsigned LO_MSB = 7;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] AD_RST = 16'h0000;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [3:0] SEL_RST = 4'h0;

    // ------------------------------------------------------------------
    // State types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        NBI_M_IDLE = 3'b000,
        NBI_M_T1 = 3'b001,
        NBI_M_T2 = 3'b010,
        NBI_M_T3 = 3'b011,
        NBI_M_TW = 3'b100,
        NBI_M_T4 = 3'b101
    } nbi_mst_e;

    typedef enum logic [1:0] {
        NBI_S_IDLE = 2'b00,
        NBI_S_SYNC = 2'b01,
        NBI_S_ACK = 2'b10
    } nbi_slv_e;

endpackage : nbi_pkg

//--- logic/nbi_sel_latch.sv
// Register select latch for slave accesses.
// Assumes the strobe and select inputs are synchronous to the clock.
`timescale 1ns/1ps
module nbi_sel_latch (
    // Clock and reset.
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    // Latch control and data.
    input wire logic i_en,
    input wire logic i_strobe,
    input wire logic [3:0] i_sel,
    output logic [3:0] o_sel_q
);

    logic strobe_q;

    // Remember the strobe so a falling edge can be seen.
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            strobe_q <= 1'b0;
        end else begin
            strobe_q <= i_strobe;
        end
    end

    // Follow the inputs while the strobe is high and on the clock that sees its fall, then freeze.
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_sel_q <= nbi_pkg::SEL_RST;
        end else if (i_en && (i_strobe || strobe_q)) begin
            o_sel_q <= i_sel;
        end
    end

    transparent_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        (i_en && i_strobe) |=> (o_sel_q == $past(i_sel)))
        else $error("Select latch not transparent while strobe high.");

    fall_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        (i_en && strobe_q && !i_strobe) ##1 (i_en && !i_strobe)
        |=> $stable(o_sel_q))
        else $error("Select changed after strobe fell.");

endmodule : nbi_sel_latch

//--- test/nbi_mem_model.sv
// Buffer memory and shared-wire model for the network bus interface.
// Assumes the bench hands in its own host drive so that one place
// resolves every driver of the shared address/data wires.
`timescale 1ns/1ps
module nbi_mem_model (
    // Clock and reset.
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    // Device side of the shared bus and its strobes.
    input wire logic [15:0] i_dev_bus,
    input wire logic i_dev_lo_oe_n,
    input wire logic i_dev_hi_oe_n,
    input wire logic i_addr_strobe,
    input wire logic i_addr_strobe_oe_n,
    input wire logic i_wr_n,
    input wire logic i_rd_n,
    input wire logic i_strobe_oe_n,
    // Host drive and memory speed.
    input wire logic [15:0] i_host_bus,
    input wire logic i_host_oe_n,
    input wire logic [3:0] i_waits,
    // Resolved wire and ready.
    output logic [15:0] o_bus,
    output logic o_ready
);
    logic [15:0] mem [0:255];
    logic [15:0] lat_q;
    logic [15:0] last_q;
    logic [3:0] cnt_q;
    logic wr_q;
    logic rd_act;
    logic wr_act;

    // ------------------------------------------------------------------
    // Wire resolution
    // ------------------------------------------------------------------
    // Strobes only count while the device actually drives them.
    assign rd_act = !i_strobe_oe_n && !i_rd_n;
    assign wr_act = !i_strobe_oe_n && !i_wr_n;
    // An undriven wire shows the inverse of its last level, so a stale
    // value can never pass for fresh data.
    always_comb begin
        o_bus = ~last_q;
        if (!i_host_oe_n) o_bus = i_host_bus;
        if (rd_act) o_bus = mem[lat_q[7:0]];
        if (!i_dev_lo_oe_n) o_bus[7:0] = i_dev_bus[7:0];
        if (!i_dev_hi_oe_n) o_bus[15:8] = i_dev_bus[15:8];
    end

    // Ready stays high for the requested number of waits from the third
    // state onwards.
    assign o_ready = (cnt_q != 4'h0) && (cnt_q <= i_waits);

    // ------------------------------------------------------------------
    // Latches and counters
    // ------------------------------------------------------------------
    // External address latch follows the wire while the strobe is high.
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            lat_q <= 16'h0000;
            last_q <= 16'h0000;
            cnt_q <= 4'h0;
            wr_q <= 1'b0;
        end else begin
            if (!i_addr_strobe_oe_n && i_addr_strobe) lat_q <= o_bus;
            last_q <= o_bus;
            cnt_q <= (rd_act || wr_act) ? cnt_q + 4'h1 : 4'h0;
            wr_q <= wr_act;
        end
    end

    // Memory takes the wire at the rising edge of the write strobe.
    always_ff @(posedge i_sys_clk) begin
        if (wr_q && !wr_act) mem[lat_q[7:0]] <= o_bus;
    end
endmodule : nbi_mem_model

//--- test/tb_network_ctrl_bus_interface.sv
// Self-checking bench for the network bus interface.
// Assumes the memory model resolves the shared wire and drives ready.
`timescale 1ns/1ps
module tb_network_ctrl_bus_interface;
    logic clk, rstn, las_in, las_out, las_oe_n, lo_oe_n, hi_oe_n;
    logic sel_n, srd_n, swr_n, ack_n, grant, ready, mwr_n, mrd_n;
    logic mst_oe_n, reg_rd, reg_wr, dma_req, dma_write, byte_mode;
    logic dma_done, host_oe_n;
    logic [15:0] bus_in, bus_out, dma_addr, dma_wdata, dma_rdata, host_bus;
    logic [7:0] reg_rdata, reg_wdata;
    logic [3:0] rsel, reg_sel, waits;
    int failures = 0;
    int cmp_count = 0;

    // ------------------------------------------------------------------
    // Instances
    // ------------------------------------------------------------------
    nbi_bus_interface nbi_bus_interface_inst (
        .i_sys_clk(clk), .i_rstn(rstn), .i_shared_addr_data_bus(bus_in),
        .o_shared_addr_data_bus(bus_out), .o_bus_lo_oe_n(lo_oe_n),
        .o_bus_hi_oe_n(hi_oe_n), .i_low_address_strobe(las_in),
        .o_low_address_strobe(las_out), .o_low_address_strobe_oe_n(las_oe_n),
        .i_slave_sel_n(sel_n), .i_slave_read_strobe_n(srd_n),
        .i_slave_write_strobe_n(swr_n), .i_register_select(rsel),
        .o_ack_n(ack_n), .i_bus_grant(grant), .i_ready(ready),
        .o_master_write_strobe_n(mwr_n), .o_master_read_strobe_n(mrd_n),
        .o_master_strobe_oe_n(mst_oe_n), .i_reg_rdata(reg_rdata),
        .o_reg_rd(reg_rd), .o_reg_wr(reg_wr), .o_reg_sel(reg_sel),
        .o_reg_wdata(reg_wdata), .i_dma_req(dma_req),
        .i_dma_write(dma_write), .i_byte_mode(byte_mode),
        .i_dma_addr(dma_addr), .i_dma_wdata(dma_wdata),
        .o_dma_done(dma_done), .o_dma_rdata(dma_rdata));
    nbi_mem_model nbi_mem_model_inst (
        .i_sys_clk(clk), .i_rstn(rstn), .i_dev_bus(bus_out),
        .i_dev_lo_oe_n(lo_oe_n), .i_dev_hi_oe_n(hi_oe_n),
        .i_addr_strobe(las_out), .i_addr_strobe_oe_n(las_oe_n),
        .i_wr_n(mwr_n), .i_rd_n(mrd_n), .i_strobe_oe_n(mst_oe_n),
        .i_host_bus(host_bus), .i_host_oe_n(host_oe_n), .i_waits(waits),
        .o_bus(bus_in), .o_ready(ready));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input string name, input logic [15:0] exp,
        input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic results();
        if (failures == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results

    // One memory cycle, walked state by state; d is the data expected in
    // memory for reads.
    task automatic run_dma(input logic w, input logic b,
        input logic [15:0] a, input logic [15:0] d, input int n_wait);
        int n;
        logic [15:0] exp;
        n = 1;
        exp = b ? {a[15:8], d[7:0]} : d;
        @(posedge clk);
        waits <= 4'(n_wait);
        dma_req <= 1'b1;
        dma_write <= w;
        byte_mode <= b;
        dma_addr <= a;
        dma_wdata <= d;
        @(posedge clk);
        dma_req <= 1'b0;
        #1;
        chk("t1 bus", a, bus_out);
        chk("t1 oe", 2'b00, {lo_oe_n, hi_oe_n});
        chk("t1 strobe", 2'b10, {las_out, las_oe_n});
        @(posedge clk);
        #1;
        chk("t2 dir", w ? 2'b01 : 2'b10, {mwr_n, mrd_n});
        chk("t2 oe", {~w, ~(w | b)}, {lo_oe_n, hi_oe_n});
        if (w | b) chk("t2 hi", exp[15:8], bus_out[15:8]);
        if (w) chk("t2 lo", exp[7:0], bus_out[7:0]);
        for (int k = 0; k < 16 && (!mwr_n || !mrd_n); k++) begin
            @(posedge clk);
            #1;
            if (!mwr_n || !mrd_n) n++;
        end
        if (n > 15) begin
            failures++;
            results();
        end
        chk("strobe len", 16'(2 + n_wait), 16'(n));
        if (w) chk("t4 data", exp, bus_out);
        @(posedge clk);
        #1;
        chk("done", 1'b1, dma_done);
        chk("idle oe", 3'b111, {lo_oe_n, hi_oe_n, las_oe_n});
        if (w) chk("mem", exp, nbi_mem_model_inst.mem[a[7:0]]);
        else chk("rdata", exp[7:0], dma_rdata[7:0]);
        if (!w && !b) chk("rdata hi", exp[15:8], dma_rdata[15:8]);
    endtask : run_dma

    // One register access by the host, read or write.
    task automatic slave_acc(input logic w, input logic [3:0] s,
        input logic [7:0] d);
        @(posedge clk);
        sel_n <= 1'b0;
        srd_n <= w;
        swr_n <= ~w;
        rsel <= s;
        reg_rdata <= d;
        host_bus <= {8'h00, d};
        host_oe_n <= ~w;
        @(posedge clk);
        #1;
        chk("reg pulse", {~w, 1'b0}, {reg_rd, reg_wr});
        @(posedge clk);
        #1;
        chk("ack", 1'b0, ack_n);
        chk("sel", s, reg_sel);
        chk("slave oe", {w, 1'b1}, {lo_oe_n, hi_oe_n});
        if (w) chk("wr", {1'b1, d}, {reg_wr, reg_wdata});
        else chk("rd data", d, bus_out[7:0]);
        @(posedge clk);
        sel_n <= 1'b1;
        srd_n <= 1'b1;
        swr_n <= 1'b1;
        host_oe_n <= 1'b1;
        @(posedge clk);
        #1;
        chk("release", 3'b111, {ack_n, lo_oe_n, hi_oe_n});
    endtask : slave_acc

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // A request without grant must leave the address strobe and master strobes floating, with no done.
    task automatic no_grant();
        logic seen;
        seen = 1'b0;
        @(posedge clk);
        dma_req <= 1'b1;
        dma_write <= 1'b1;
        repeat (6) begin
            @(posedge clk);
            #1;
            seen = seen | !las_oe_n | !mst_oe_n | dma_done;
        end
        chk("no grant", 1'b0, seen);
        @(posedge clk);
        dma_req <= 1'b0;
        grant <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk("grant oe", 1'b0, mst_oe_n);
    endtask : no_grant

    // Select is caught at the strobe fall and later changes are ignored.
    task automatic sel_hold();
        @(posedge clk);
        sel_n <= 1'b0;
        srd_n <= 1'b0;
        rsel <= 4'hA;
        @(posedge clk);
        las_in <= 1'b0;
        @(posedge clk);
        rsel <= 4'h5;
        repeat (2) @(posedge clk);
        #1;
        chk("sel hold", 4'hA, reg_sel);
        @(posedge clk);
        sel_n <= 1'b1;
        srd_n <= 1'b1;
        las_in <= 1'b1;
        repeat (2) @(posedge clk);
    endtask : sel_hold

    // ------------------------------------------------------------------
    // Clock and main sequence
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Inputs start idle with reset held; every later change is clocked.
    initial begin
        {rstn, grant, dma_req, dma_write, byte_mode} = 5'b00000;
        {las_in, sel_n, srd_n, swr_n, host_oe_n} = 5'b11111;
        {dma_addr, dma_wdata, host_bus} = {3{16'h0000}};
        {rsel, waits, reg_rdata} = 16'h0000;
        repeat (15) @(posedge clk);
        #1;
        chk("reset", 5'h1F,
            {lo_oe_n, hi_oe_n, las_oe_n, mst_oe_n, ack_n});
        @(posedge clk);
        rstn <= 1'b1;
        no_grant();
        run_dma(1'b1, 1'b0, 16'h3C12, 16'hA55A, 0);
        run_dma(1'b1, 1'b1, 16'hC3F0, 16'h1234, 1);
        run_dma(1'b0, 1'b0, 16'h3C12, 16'hA55A, 2);
        run_dma(1'b0, 1'b1, 16'hC3F0, 16'h1234, 0);
        slave_acc(1'b0, 4'h9, 8'h6C);
        slave_acc(1'b1, 4'h3, 8'hB7);
        sel_hold();
        results();
    end
endmodule : tb_network_ctrl_bus_interface
